// ### common/rrs_pkg.sv
// Shared constants and types for the receive reset sequencer
package rrs_pkg;
    // Ordering select encodings
    localparam logic [1:0] ORDER_SEQUENTIAL = 2'h0;
    localparam logic [1:0] ORDER_SINGLE = 2'h3;
    // Mask and rate-select widths
    localparam int PHY_MASK_W = 7;
    localparam int CODING_MASK_W = 5;
    localparam int DPI_MASK_W = 2;
    localparam int RATE_W = 3;
    // Full-reset mask values
    localparam logic [6:0] PHY_MASK_ALL = 7'h7F;
    localparam logic [4:0] CODING_MASK_ALL = 5'h1F;
    localparam logic [1:0] DPI_MASK_ALL = 2'h3;
    // Coding-layer mask bit positions
    localparam int CODING_PRBS_BIT = 1;
    localparam int CODING_EBUF_BIT = 2;
    localparam int CODING_EYE_BIT = 3;
    // Single-mode coding masks
    localparam logic [4:0] CODING_MASK_EBUF = 5'h04;
    localparam logic [4:0] CODING_MASK_PRBS = 5'h02;
    localparam logic [4:0] CODING_MASK_EYE = 5'h08;
    // Hold time of one internal region reset, in cycles
    localparam logic [3:0] REGION_HOLD_CYCLES = 4'h4;
    // Settle wait before the host starts a run
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_MIN_NS = 300;
    localparam int SETTLE_CYCLES =
        (SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Trigger pulse width in cycles (one reference period, rounded up)
    localparam logic [3:0] TRIGGER_CYCLES = 4'h2;
    // APB register offsets of the host controller
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    // Control register fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_KIND_LSB = 1;
    // Host run kinds
    typedef enum logic [1:0] {
        RRS_KIND_FULL,
        RRS_KIND_EBUF,
        RRS_KIND_PRBS,
        RRS_KIND_EYE
    } rrs_kind_t;
    // Device sequencer states
    typedef enum logic [2:0] {
        RRS_D_IDLE,
        RRS_D_ARMED,
        RRS_D_PHY,
        RRS_D_DPI,
        RRS_D_CODING,
        RRS_D_SINGLE
    } rrs_dstate_t;
    // Host sequencer states
    typedef enum logic [2:0] {
        RRS_H_IDLE,
        RRS_H_SETTLE,
        RRS_H_TRIG,
        RRS_H_LOCKWAIT,
        RRS_H_DONEWAIT
    } rrs_hstate_t;
endpackage : rrs_pkg

// ### common/rrs_link_if.sv
// Link between the receive reset sequencer and its controlling logic
interface rrs_link_if;
    logic [1:0] rx_reset_order_select;
    logic [6:0] rx_phy_region_mask;
    logic [4:0] rx_coding_region_mask;
    logic [1:0] dpi_reset_mask;
    logic rx_reset_trigger;
    logic dpi_reset_trigger;
    logic rx_user_ready;
    logic eye_scan_clear;
    logic oob_detector_clear;
    logic clock_recovery_clear;
    logic prbs_error_count_clear;
    logic coding_layer_direct_clear;
    logic rx_reset_complete;
    logic pll_locked;
    logic lock_osc_clear;
    logic lock_osc_clear_complete;
    logic power_good;

    modport device (
        input rx_reset_order_select, rx_phy_region_mask,
        input rx_coding_region_mask, dpi_reset_mask,
        input rx_reset_trigger, dpi_reset_trigger, rx_user_ready,
        input eye_scan_clear, oob_detector_clear, clock_recovery_clear,
        input prbs_error_count_clear, coding_layer_direct_clear,
        input lock_osc_clear,
        output rx_reset_complete, lock_osc_clear_complete
    );
    modport host (
        output rx_reset_order_select, rx_phy_region_mask,
        output rx_coding_region_mask, dpi_reset_mask,
        output rx_reset_trigger, dpi_reset_trigger, rx_user_ready,
        output eye_scan_clear, oob_detector_clear, clock_recovery_clear,
        output prbs_error_count_clear, coding_layer_direct_clear,
        output lock_osc_clear,
        input rx_reset_complete, lock_osc_clear_complete,
        input pll_locked, power_good
    );
endinterface : rrs_link_if

// ### hdl/rrs_device.sv
// Receive reset sequencer: the transceiver's own reset state machine
//
// Design decisions made in the host, not here: the register offsets and the APB interface to the registers.
module rrs_device (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link to the controlling logic
    rrs_link_if.device link,
    // Transceiver-side status and options
    input wire logic [2:0] rx_line_rate_select,
    input wire logic buffer_clear_on_realign,
    input wire logic buffer_clear_on_bond_change,
    input wire logic comma_realign,
    input wire logic bond_master_select,
    input wire logic bond_slave_select,
    input wire logic [2:0] bond_level_select,
    // Internal region resets, visible to the user side
    output logic [6:0] phyRegionReset,
    output logic [1:0] dpiRegionReset,
    output logic [4:0] codingRegionReset,
    output logic clockRecoveryReset,
    output logic oobDetectorReset
);
    typedef struct packed {
        rrs_pkg::rrs_dstate_t state;
        logic [3:0] holdCount;
        logic [2:0] stepIndex;
        logic [6:0] phyMask;
        logic [4:0] codingMask;
        logic [1:0] dpiMask;
        logic trigPrev;
        logic [2:0] ratePrev;
        logic [4:0] bondPrev;
        logic rateRun;
        logic complete;
        logic oscComplete;
        logic [6:0] phyReset;
        logic [1:0] dpiReset;
        logic [4:0] codingReset;
        logic cdrReset;
        logic oobReset;
    } rrs_dev_t;

    rrs_dev_t cur;
    rrs_dev_t next_cur;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic trigFall;
        logic rateChange;
        logic bondChange;
        logic holdDone;
        logic [4:0] bondNow;
        trigFall = 1'b0;
        rateChange = 1'b0;
        bondChange = 1'b0;
        holdDone = 1'b0;
        bondNow = {bond_master_select, bond_slave_select, bond_level_select};
        next_cur = cur;
        trigFall = cur.trigPrev && !link.rx_reset_trigger;
        rateChange = rx_line_rate_select != cur.ratePrev;
        bondChange = bondNow != cur.bondPrev;
        holdDone = cur.holdCount == 4'h0;
        next_cur.trigPrev = link.rx_reset_trigger;
        next_cur.ratePrev = rx_line_rate_select;
        next_cur.bondPrev = bondNow;
        if (!holdDone) begin
            next_cur.holdCount = cur.holdCount - 4'h1;
        end
        // Direct component clears, outside any triggered run
        next_cur.cdrReset = link.clock_recovery_clear;
        next_cur.oobReset = link.oob_detector_clear;
        next_cur.codingReset = 5'h00;
        next_cur.codingReset[rrs_pkg::CODING_EYE_BIT] =
            link.eye_scan_clear;
        next_cur.codingReset[rrs_pkg::CODING_PRBS_BIT] =
            link.prbs_error_count_clear;
        if (link.coding_layer_direct_clear) begin
            next_cur.codingReset = rrs_pkg::CODING_MASK_ALL;
        end
        // Automatic elastic buffer clears
        if ((buffer_clear_on_realign && comma_realign) ||
            (buffer_clear_on_bond_change && bondChange)) begin
            next_cur.codingReset[rrs_pkg::CODING_EBUF_BIT] = 1'b1;
        end
        // Oscillator reset-done follows its clear
        next_cur.oscComplete = !link.lock_osc_clear;
        next_cur.phyReset = 7'h00;
        next_cur.dpiReset = 2'h0;
        unique case (cur.state)
            rrs_pkg::RRS_D_IDLE: begin
                // A trigger or a change of rx_line_rate_select starts a run
                if (link.rx_reset_trigger) begin
                    next_cur.state = rrs_pkg::RRS_D_ARMED;
                    next_cur.complete = 1'b0;
                end else if (rateChange) begin
                    next_cur.rateRun = 1'b1;
                    next_cur.phyMask = rrs_pkg::PHY_MASK_ALL;
                    next_cur.dpiMask = rrs_pkg::DPI_MASK_ALL;
                    next_cur.codingMask = rrs_pkg::CODING_MASK_ALL;
                    next_cur.state = rrs_pkg::RRS_D_PHY;
                    next_cur.stepIndex = 3'h0;
                    next_cur.holdCount = rrs_pkg::REGION_HOLD_CYCLES;
                    next_cur.complete = 1'b0;
                end
            end
            rrs_pkg::RRS_D_ARMED: begin
                // Hold off until the trigger falls
                if (trigFall) begin
                    next_cur.phyMask = link.rx_phy_region_mask;
                    next_cur.codingMask = link.rx_coding_region_mask;
                    next_cur.dpiMask = link.dpi_reset_mask;
                    next_cur.holdCount = rrs_pkg::REGION_HOLD_CYCLES;
                    next_cur.stepIndex = 3'h0;
                    if (link.rx_reset_order_select ==
                        rrs_pkg::ORDER_SINGLE) begin
                        next_cur.state = rrs_pkg::RRS_D_SINGLE;
                    end else begin
                        next_cur.state = rrs_pkg::RRS_D_PHY;
                    end
                end
            end
            rrs_pkg::RRS_D_PHY: begin
                // One physical-layer region at a time
                next_cur.phyReset[cur.stepIndex] =
                    cur.phyMask[cur.stepIndex];
                if (holdDone || !cur.phyMask[cur.stepIndex]) begin
                    next_cur.holdCount = rrs_pkg::REGION_HOLD_CYCLES;
                    if (cur.stepIndex == 3'h6) begin
                        next_cur.stepIndex = 3'h0;
                        next_cur.state = rrs_pkg::RRS_D_DPI;
                    end else begin
                        next_cur.stepIndex = cur.stepIndex + 3'h1;
                    end
                end
            end
            rrs_pkg::RRS_D_DPI: begin
                next_cur.dpiReset = cur.dpiMask;
                if (holdDone || cur.dpiMask == 2'h0) begin
                    next_cur.holdCount = rrs_pkg::REGION_HOLD_CYCLES;
                    next_cur.state = rrs_pkg::RRS_D_CODING;
                end
            end
            rrs_pkg::RRS_D_CODING: begin
                next_cur.codingReset = cur.codingMask;
                // Coding region released only once user ready
                if ((holdDone && link.rx_user_ready) ||
                    cur.codingMask == 5'h00) begin
                    next_cur.state = rrs_pkg::RRS_D_IDLE;
                    next_cur.rateRun = 1'b0;
                    next_cur.complete = 1'b1;
                end
            end
            rrs_pkg::RRS_D_SINGLE: begin
                // All selected regions together
                next_cur.phyReset = cur.phyMask;
                next_cur.dpiReset = cur.dpiMask;
                next_cur.codingReset = cur.codingMask;
                if (holdDone && (link.rx_user_ready ||
                    cur.codingMask == 5'h00)) begin
                    next_cur.state = rrs_pkg::RRS_D_IDLE;
                    next_cur.complete = 1'b1;
                end
            end
            default: begin
                next_cur.state = rrs_pkg::RRS_D_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.state <= rrs_pkg::RRS_D_IDLE;
            cur.ratePrev <= rx_line_rate_select;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign link.rx_reset_complete = cur.complete;
    assign link.lock_osc_clear_complete = cur.oscComplete;
    assign phyRegionReset = cur.phyReset;
    assign dpiRegionReset = cur.dpiReset;
    assign codingRegionReset = cur.codingReset;
    assign clockRecoveryReset = cur.cdrReset;
    assign oobDetectorReset = cur.oobReset;
endmodule : rrs_device

// ### hdl/rrs_host.sv
// Controlling logic for the receive reset sequencer, commanded over APB
module rrs_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock stability from the user clocking
    input wire logic clocks_stable,
    // Link to the device
    rrs_link_if.host link
);
    typedef struct packed {
        rrs_pkg::rrs_hstate_t state;
        rrs_pkg::rrs_kind_t kind;
        logic [7:0] count;
        logic trig;
        logic dpiTrig;
        logic oscClear;
        logic [1:0] order;
        logic [6:0] phyMask;
        logic [4:0] codingMask;
        logic [1:0] dpiMask;
        logic userReady;
        logic doneSticky;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } rrs_host_t;

    rrs_host_t cur;
    rrs_host_t next_cur;

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic setup;
        logic access;
        logic go;
        setup = psel && !penable;
        access = psel && penable && cur.ready;
        go = 1'b0;
        next_cur = cur;
        next_cur.ready = setup;
        next_cur.err = 1'b0;
        next_cur.userReady = clocks_stable;
        // Read data and error decoded in setup, answered next cycle
        if (setup) begin
            next_cur.rdata = 32'h0;
            unique case (paddr)
                rrs_pkg::REG_CTRL: begin
                    next_cur.rdata = {29'h0, cur.kind, 1'b0};
                end
                rrs_pkg::REG_STATUS: begin
                    next_cur.rdata = {26'h0, link.power_good,
                        link.pll_locked, link.rx_reset_complete,
                        cur.state != rrs_pkg::RRS_H_IDLE, cur.doneSticky,
                        cur.userReady};
                end
                rrs_pkg::REG_MASK: begin
                    next_cur.rdata = {18'h0, cur.dpiMask, cur.codingMask,
                        cur.phyMask};
                end
                default: begin
                    next_cur.err = 1'b1;
                end
            endcase
        end
        // A go write lands only at the access edge, with pready high
        go = access && pwrite && paddr == rrs_pkg::REG_CTRL &&
            pwdata[rrs_pkg::CTRL_GO_BIT] &&
            cur.state == rrs_pkg::RRS_H_IDLE;
        unique case (cur.state)
            rrs_pkg::RRS_H_IDLE: begin
                if (go) begin
                    next_cur.kind = rrs_pkg::rrs_kind_t'(
                        pwdata[rrs_pkg::CTRL_KIND_LSB +: 2]);
                    next_cur.doneSticky = 1'b0;
                    next_cur.state = rrs_pkg::RRS_H_SETTLE;
                    next_cur.count = 8'(rrs_pkg::SETTLE_CYCLES);
                    if (next_cur.kind == rrs_pkg::RRS_KIND_FULL) begin
                        // Full: sequential, every mask set
                        next_cur.order = rrs_pkg::ORDER_SEQUENTIAL;
                        next_cur.phyMask = rrs_pkg::PHY_MASK_ALL;
                        next_cur.codingMask = rrs_pkg::CODING_MASK_ALL;
                        next_cur.dpiMask = rrs_pkg::DPI_MASK_ALL;
                        next_cur.oscClear = 1'b1;
                    end else begin
                        next_cur.order = rrs_pkg::ORDER_SINGLE;
                        next_cur.phyMask = 7'h00;
                        next_cur.dpiMask = 2'h0;
                        unique case (next_cur.kind)
                            rrs_pkg::RRS_KIND_PRBS: next_cur.codingMask =
                                rrs_pkg::CODING_MASK_PRBS;
                            rrs_pkg::RRS_KIND_EYE: next_cur.codingMask =
                                rrs_pkg::CODING_MASK_EYE;
                            default: next_cur.codingMask =
                                rrs_pkg::CODING_MASK_EBUF;
                        endcase
                    end
                end
            end
            rrs_pkg::RRS_H_SETTLE: begin
                // Masks settle before the trigger rises
                if (cur.count == 8'h0) begin
                    if (link.power_good) begin
                        next_cur.state = rrs_pkg::RRS_H_TRIG;
                        next_cur.trig = 1'b1;
                        next_cur.dpiTrig =
                            cur.kind == rrs_pkg::RRS_KIND_FULL;
                        next_cur.count = 8'(rrs_pkg::TRIGGER_CYCLES);
                    end
                end else begin
                    next_cur.count = cur.count - 8'h1;
                end
            end
            rrs_pkg::RRS_H_TRIG: begin
                // Trigger at least one reference period
                if (cur.count == 8'h0) begin
                    next_cur.state = rrs_pkg::RRS_H_LOCKWAIT;
                end else begin
                    next_cur.count = cur.count - 8'h1;
                end
            end
            rrs_pkg::RRS_H_LOCKWAIT: begin
                // Oscillator freed on lock, trigger on its done
                if (link.pll_locked && link.power_good) begin
                    next_cur.oscClear = 1'b0;
                end
                if (link.pll_locked && !cur.oscClear &&
                    link.lock_osc_clear_complete) begin
                    next_cur.trig = 1'b0;
                    next_cur.dpiTrig = 1'b0;
                    next_cur.state = rrs_pkg::RRS_H_DONEWAIT;
                end
            end
            rrs_pkg::RRS_H_DONEWAIT: begin
                // Masks stay put until completion
                if (link.rx_reset_complete && !cur.trig) begin
                    next_cur.doneSticky = 1'b1;
                    next_cur.state = rrs_pkg::RRS_H_IDLE;
                end
            end
            default: begin
                next_cur.state = rrs_pkg::RRS_H_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // State register; direct clears tied low
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cur <= '0;
            cur.state <= rrs_pkg::RRS_H_IDLE;
            cur.phyMask <= rrs_pkg::PHY_MASK_ALL;
            cur.codingMask <= rrs_pkg::CODING_MASK_ALL;
            cur.dpiMask <= rrs_pkg::DPI_MASK_ALL;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = cur.rdata;
    assign pready = cur.ready;
    assign pslverr = cur.err;
    assign link.rx_reset_order_select = cur.order;
    assign link.rx_phy_region_mask = cur.phyMask;
    assign link.rx_coding_region_mask = cur.codingMask;
    assign link.dpi_reset_mask = cur.dpiMask;
    assign link.rx_reset_trigger = cur.trig;
    assign link.dpi_reset_trigger = cur.dpiTrig;
    assign link.rx_user_ready = cur.userReady;
    assign link.lock_osc_clear = cur.oscClear;
    assign link.eye_scan_clear = 1'b0;
    assign link.oob_detector_clear = 1'b0;
    assign link.clock_recovery_clear = 1'b0;
    assign link.prbs_error_count_clear = 1'b0;
    assign link.coding_layer_direct_clear = 1'b0;
endmodule : rrs_host

// ### bench/rrs_link_props.sv
// Link checks between host and device of the reset sequencer
module rrs_link_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host-driven link signals
    input wire logic [1:0] rx_reset_order_select,
    input wire logic [6:0] rx_phy_region_mask,
    input wire logic [4:0] rx_coding_region_mask,
    input wire logic [1:0] dpi_reset_mask,
    input wire logic rx_reset_trigger,
    input wire logic dpi_reset_trigger,
    input wire logic rx_user_ready,
    // Device and status signals
    input wire logic rx_reset_complete,
    input wire logic lock_osc_clear_complete,
    input wire logic pll_locked,
    input wire logic power_good
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic seenTrig;
    logic running;
    ////////////////////////////////////////////////////////////////////
    // Trigger seen since reset; triggered run in progress
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seenTrig <= 1'b0;
            running <= 1'b0;
        end else begin
            seenTrig <= seenTrig | rx_reset_trigger;
            running <= (running | $fell(rx_reset_trigger)) &
                ~rx_reset_complete;
        end
    end
    ////////////////////////////////////////////////////////////////////
    chk_done_drops: assert property (
        $rose(rx_reset_trigger) |-> ##[1:2] !rx_reset_complete)
        else $error("complete stayed high after trigger");
    chk_user_gate: assert property (
        $rose(rx_reset_complete) && (|rx_coding_region_mask)
        |-> rx_user_ready) else $error("done without user ready");
    chk_no_auto_run: assert property (
        !seenTrig |-> !rx_reset_complete) else $error("run without trigger");
    chk_masks_held: assert property (
        running |-> $stable({rx_reset_order_select, rx_phy_region_mask,
        rx_coding_region_mask, dpi_reset_mask}))
        else $error("masks changed during run");
    chk_full_masks: assert property (
        $rose(rx_reset_trigger) &&
        rx_reset_order_select == rrs_pkg::ORDER_SEQUENTIAL
        |-> rx_phy_region_mask == rrs_pkg::PHY_MASK_ALL &&
        rx_coding_region_mask == rrs_pkg::CODING_MASK_ALL &&
        dpi_reset_mask == rrs_pkg::DPI_MASK_ALL)
        else $error("sequential run without full masks");
    chk_power_first: assert property (
        $fell(rx_reset_trigger) |-> power_good)
        else $error("trigger released before power good");
    chk_lock_first: assert property (
        $fell(rx_reset_trigger) |-> pll_locked && lock_osc_clear_complete)
        else $error("trigger released before lock");
    chk_trig_width: assert property (
        $rose(rx_reset_trigger) |=> rx_reset_trigger[*2])
        else $error("trigger pulse too short");
    chk_dpi_paired: assert property (
        $fell(rx_reset_trigger) &&
        rx_reset_order_select == rrs_pkg::ORDER_SEQUENTIAL
        |-> $fell(dpi_reset_trigger))
        else $error("full run without paired dpi trigger");
    cov_seq_run: cover property ($fell(rx_reset_trigger) &&
        rx_reset_order_select == rrs_pkg::ORDER_SEQUENTIAL);
    cov_single_run: cover property ($fell(rx_reset_trigger) &&
        rx_reset_order_select == rrs_pkg::ORDER_SINGLE);
    cov_done: cover property ($rose(rx_reset_complete));
endmodule : rrs_link_props

// ### bench/rx_reset_sequencer_tb_top.sv
// Testbench joining host and device over the reset link
module rx_reset_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rst_n = 1'b0, err, hit;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic clocksStable = 1'b0, realignEn = 1'b0, commaRealign = 1'b0;
    logic bondEn = 1'b0, bondMaster = 1'b0, bondSlave = 1'b0, cdrR, oobR;
    logic [2:0] rateSel = 3'h0, bondLevel = 3'h0;
    logic [6:0] phyR, phyOr = 7'h00;
    logic [1:0] dpiR;
    logic [4:0] codR, codOr = 5'h00;
    logic [4:0] cm [4] = '{5'h1F, 5'h04, 5'h02, 5'h08};
    int err_total = 0, checked = 0;
    rrs_link_if lnk ();
    rrs_device rrs_device_inst (.core_clk, .rst_n, .link(lnk),
        .rx_line_rate_select(rateSel), .buffer_clear_on_realign(realignEn),
        .buffer_clear_on_bond_change(bondEn), .comma_realign(commaRealign),
        .bond_master_select(bondMaster), .bond_slave_select(bondSlave),
        .bond_level_select(bondLevel), .phyRegionReset(phyR),
        .dpiRegionReset(dpiR), .codingRegionReset(codR),
        .clockRecoveryReset(cdrR), .oobDetectorReset(oobR));
    rrs_host rrs_host_inst (.core_clk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr,
        .clocks_stable(clocksStable), .link(lnk));
    rrs_link_props rrs_link_props_inst (.core_clk, .rst_n,
        .rx_reset_order_select(lnk.rx_reset_order_select),
        .rx_phy_region_mask(lnk.rx_phy_region_mask),
        .rx_coding_region_mask(lnk.rx_coding_region_mask),
        .dpi_reset_mask(lnk.dpi_reset_mask),
        .rx_reset_trigger(lnk.rx_reset_trigger),
        .dpi_reset_trigger(lnk.dpi_reset_trigger),
        .rx_user_ready(lnk.rx_user_ready),
        .rx_reset_complete(lnk.rx_reset_complete),
        .lock_osc_clear_complete(lnk.lock_osc_clear_complete),
        .pll_locked(lnk.pll_locked), .power_good(lnk.power_good));
    // Clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Region resets gathered while a run is open
    always @(posedge core_clk) begin
        phyOr <= (lnk.rx_reset_complete === 1'b1) ? 7'h00 : phyOr | phyR;
        codOr <= (lnk.rx_reset_complete === 1'b1) ? 5'h00 : codOr | codR;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    // One APB transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wait_done(input logic lvl);
        int n;
        n = 0;
        while (lnk.rx_reset_complete !== lvl && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        cmp(32'(lnk.rx_reset_complete), 32'(lvl));
    endtask : wait_done
    // Poll for the elastic buffer clear
    task automatic ebuf_seen();
        hit = 1'b0;
        repeat (8) begin
            @(posedge core_clk);
            hit = hit | codR[2];
        end
        cmp(32'(hit), 32'h1);
    endtask : ebuf_seen
    task automatic end_of_test();
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // Watchdog
    initial begin
        #1000000;
        err_total++;
        end_of_test();
    end
    // Main sequence
    initial begin
        lnk.pll_locked = 1'b0;
        lnk.power_good = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge core_clk);
        cmp(32'(lnk.rx_reset_complete), 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        cmp(rd, 32'h3FFF);
        apb(1'b1, 8'h00, 32'h1);
        repeat (40) @(posedge core_clk);
        cmp(32'(lnk.rx_reset_complete), 32'h0);
        cmp(32'(lnk.rx_reset_trigger), 32'h0);
        lnk.power_good <= 1'b1;
        repeat (40) @(posedge core_clk);
        cmp(32'(lnk.rx_reset_trigger), 32'h1);
        lnk.pll_locked <= 1'b1;
        repeat (200) @(posedge core_clk);
        cmp(32'(lnk.rx_reset_complete), 32'h0);
        clocksStable <= 1'b1;
        wait_done(1'b1);
        cmp(32'(phyOr), 32'h7F);
        cmp(32'(codOr), 32'h1F);
        apb(1'b0, 8'h04, 32'h0);
        cmp(rd, 32'h3B);
        for (int k = 1; k < 4; k++) begin
            apb(1'b1, 8'h00, 32'(k * 2 + 1));
            apb(1'b0, 8'h08, 32'h0);
            cmp({20'h0, rd[11:0]}, {20'h0, cm[k], 7'h00});
            wait_done(1'b0);
            wait_done(1'b1);
            cmp(32'(codOr), 32'(cm[k]));
            cmp(32'(phyOr), 32'h0);
            cmp(32'({cdrR, oobR, dpiR}), 32'h0);
        end
        apb(1'b0, 8'h10, 32'h0);
        cmp(32'(err), 32'h1);
        rateSel <= 3'h2;
        wait_done(1'b0);
        wait_done(1'b1);
        realignEn <= 1'b1;
        commaRealign <= 1'b1;
        ebuf_seen();
        commaRealign <= 1'b0;
        repeat (3) @(posedge core_clk);
        cmp(32'(codR), 32'h0);
        bondEn <= 1'b1;
        bondMaster <= 1'b1;
        ebuf_seen();
        end_of_test();
    end
endmodule : rx_reset_sequencer_tb_top
